/* File: rtl/owh_computer.sv */
// computer end: places data and command words and paces the acknowledges
//Contract
//- never change signals before minimum intervals
//- recognize signals at or after minimums
//- peripheral requests only when ready
//- acknowledge marks word valid for sampling
//- word may follow request with no wait
//- setup interval between word and acknowledge
//- peripheral detects minimum-length acknowledge
//- hold word after acknowledge falls
//- peripheral accepts minimum word-valid interval
//- peripheral may drop request after acknowledge
//- request must be low clearing interval first
//- handle new request before acknowledge falls
//- forced command sent without any request
//- peripheral tolerates back-to-back forced commands
//- setup 4.2 slow, 0.4 fast microseconds
//- acknowledge high 8.0 slow, 2.2 fast
//- request low 7.0 slow, 1.2 fast
//- forced gap 2.8 slow, 0.8 fast
`timescale 1ns/1ps
module owh_computer
   import owh_pkg::*;
#(
   parameter int WORD_W = OWH_WORD_W
) (
   // clock and reset
   input wire logic clock_i,
   input wire logic resetn_i,
   // user side
   input wire logic fast_i,
   input wire logic send_valid_i,
   input wire logic send_cmd_i,
   input wire logic send_force_i,
   input wire logic [WORD_W-1:0] send_word_i,
   output logic send_ready_o,
   output logic out_pending_o,
   output logic cmd_pending_o,
   // link
   owh_link_if.computer link
);
   // elaboration checks: the word must exist and the slow acknowledge, setup, hold and valid times summed must fit the counter
   if (WORD_W < 1) begin : g_bad_width
      $error("word width must be positive");
   end
   if (OWH_ACK_SLOW_CYC + OWH_SETUP_SLOW_CYC + OWH_HOLD_SLOW_CYC + OWH_VALID_SLOW_CYC >= (1 << OWH_CNT_W)) begin : g_bad_count
      $error("interval counter too narrow for the slow profile");
   end

   owh_state_type state_q;
   logic [OWH_CNT_W-1:0] cnt_q;
   logic [1:0] oreq_s_q, creq_s_q;
   logic oreq_prev_q, creq_prev_q;
   logic [OWH_CNT_W-1:0] olow_q, clow_q;
   logic out_pend_q, cmd_pend_q;
   logic is_cmd_q, forced_q, fast_q;
   logic [WORD_W-1:0] word_q;
   logic out_ack_q, cmd_ack_q, ready_q;
   logic take;

   function automatic logic [OWH_CNT_W-1:0] pick(input logic f, input int unsigned s, input int unsigned q);
      pick = f ? OWH_CNT_W'(q) : OWH_CNT_W'(s);
   endfunction : pick

   // a request counts once, on a rising edge, and only after the line sat low for the clearing interval
   function automatic logic armed(input logic now_v, input logic prev_v, input logic [OWH_CNT_W-1:0] low_v,
         input logic [OWH_CNT_W-1:0] need_v);
      armed = now_v && !prev_v && (low_v >= need_v);
   endfunction : armed

   function automatic logic [OWH_CNT_W-1:0] sat_inc(input logic [OWH_CNT_W-1:0] v);
      sat_inc = (v == '1) ? v : v + 1'b1;
   endfunction : sat_inc

   logic [OWH_CNT_W-1:0] setup_c, ack_c, hold_c, gap_c, clear_c, valid_c;
   always_comb begin
      setup_c = pick(fast_q, OWH_SETUP_SLOW_CYC, OWH_SETUP_FAST_CYC);
      ack_c = pick(fast_q, OWH_ACK_SLOW_CYC, OWH_ACK_FAST_CYC);
      hold_c = pick(fast_q, OWH_HOLD_SLOW_CYC, OWH_HOLD_FAST_CYC);
      gap_c = pick(fast_q, OWH_GAP_SLOW_CYC, OWH_GAP_FAST_CYC);
      clear_c = pick(fast_q, OWH_CLEAR_SLOW_CYC, OWH_CLEAR_FAST_CYC);
      valid_c = pick(fast_q, OWH_VALID_SLOW_CYC, OWH_VALID_FAST_CYC);
   end

   // the acknowledge may outlast its own minimum so that the word stands for the full valid time
   logic ack_done;
   assign ack_done = (cnt_q >= ack_c) && (cnt_q + setup_c + hold_c >= valid_c);

   // profile is latched only while idle so a transfer never mixes timings
   always_ff @(posedge clock_i) begin
      if (!resetn_i) fast_q <= 1'b0;
      else if (state_q == OWH_IDLE) fast_q <= fast_i;
   end

   // request lines come from another clock domain
   always_ff @(posedge clock_i) begin
      if (!resetn_i) begin
         oreq_s_q <= 2'h0;
         oreq_prev_q <= 1'b0;
      end else begin
         oreq_s_q <= {oreq_s_q[0], link.out_req};
         oreq_prev_q <= oreq_s_q[1];
      end
   end

   always_ff @(posedge clock_i) begin
      if (!resetn_i) begin
         creq_s_q <= 2'h0;
         creq_prev_q <= 1'b0;
      end else begin
         creq_s_q <= {creq_s_q[0], link.cmd_req};
         creq_prev_q <= creq_s_q[1];
      end
   end

   // low-time counters arm a request only after the clearing interval
   always_ff @(posedge clock_i) begin
      if (!resetn_i) begin
         olow_q <= '0;
         clow_q <= '0;
      end else begin
         if (oreq_prev_q) olow_q <= '0;
         else olow_q <= sat_inc(olow_q);
         if (creq_prev_q) clow_q <= '0;
         else clow_q <= sat_inc(clow_q);
      end
   end

   // pending flags: a rising edge held high; set wins over the clear from a served word
   always_ff @(posedge clock_i) begin
      if (!resetn_i) begin
         out_pend_q <= 1'b0;
         cmd_pend_q <= 1'b0;
      end else begin
         if (armed(oreq_s_q[1], oreq_prev_q, olow_q, clear_c)) out_pend_q <= 1'b1;
         else if (take && !send_cmd_i && !send_force_i) out_pend_q <= 1'b0;
         if (armed(creq_s_q[1], creq_prev_q, clow_q, clear_c)) cmd_pend_q <= 1'b1;
         else if (take && send_cmd_i && !send_force_i) cmd_pend_q <= 1'b0;
      end
   end

   // a word is taken only in idle; a request raised during the last acknowledge is already pending then
   assign take = send_valid_i && ready_q;

   always_ff @(posedge clock_i) begin
      if (!resetn_i) begin
         state_q <= OWH_IDLE;
         cnt_q <= '0;
         word_q <= '0;
         is_cmd_q <= 1'b0;
         forced_q <= 1'b0;
         out_ack_q <= 1'b0;
         cmd_ack_q <= 1'b0;
      end else begin
         case (state_q)
            OWH_IDLE: begin
               if (take) begin
                  word_q <= send_word_i;
                  is_cmd_q <= send_cmd_i | send_force_i;
                  forced_q <= send_force_i;
                  cnt_q <= OWH_CNT_W'(1);
                  state_q <= OWH_SETUP;
               end
            end
            OWH_SETUP: begin
               cnt_q <= cnt_q + 1'b1;
               if (cnt_q >= setup_c) begin
                  out_ack_q <= ~is_cmd_q;
                  cmd_ack_q <= is_cmd_q;
                  cnt_q <= OWH_CNT_W'(1);
                  state_q <= OWH_ACK;
               end
            end
            OWH_ACK: begin
               cnt_q <= cnt_q + 1'b1;
               if (ack_done) begin
                  out_ack_q <= 1'b0;
                  cmd_ack_q <= 1'b0;
                  cnt_q <= OWH_CNT_W'(1);
                  state_q <= OWH_HOLD;
               end
            end
            OWH_HOLD: begin
               cnt_q <= cnt_q + 1'b1;
               if (cnt_q >= hold_c) begin
                  cnt_q <= OWH_CNT_W'(1);
                  state_q <= OWH_GAP;
               end
            end
            OWH_GAP: begin
               cnt_q <= cnt_q + 1'b1;
               if (cnt_q >= gap_c) state_q <= OWH_IDLE;
            end
            default: state_q <= OWH_IDLE;
         endcase
      end
   end

   // ready only in idle; the user gates requested words by the pending flags
   always_ff @(posedge clock_i) begin
      if (!resetn_i) ready_q <= 1'b0;
      else ready_q <= (state_q == OWH_IDLE) && !take;
   end

   assign send_ready_o = ready_q;
   assign out_pending_o = out_pend_q;
   assign cmd_pending_o = cmd_pend_q;
   assign link.word = word_q;
   assign link.out_ack = out_ack_q;
   assign link.cmd_ack = cmd_ack_q;
endmodule : owh_computer

/* File: rtl/owh_link_if.sv */
// output channel lines between the computer end and the peripheral end
`timescale 1ns/1ps
interface owh_link_if #(parameter int WORD_W = 30);
   logic [WORD_W-1:0] word;
   logic out_ack;
   logic cmd_ack;
   logic out_req;
   logic cmd_req;
   modport computer (output word, output out_ack, output cmd_ack, input out_req, input cmd_req);
   modport peripheral (input word, input out_ack, input cmd_ack, output out_req, output cmd_req);
endinterface : owh_link_if

/* File: rtl/owh_peripheral.sv */
// peripheral end: raises requests when ready and captures acknowledged words
`timescale 1ns/1ps
module owh_peripheral
   import owh_pkg::*;
#(
   parameter int WORD_W = OWH_WORD_W
) (
   // clock and reset
   input wire logic clock_i,
   input wire logic resetn_i,
   // user side
   input wire logic fast_i,
   input wire logic want_data_i,
   input wire logic want_cmd_i,
   output logic [WORD_W-1:0] rx_word_o,
   output logic rx_valid_o,
   output logic rx_cmd_o,
   // link
   owh_link_if.peripheral link
);
   if (WORD_W < 1) begin : g_bad_width
      $error("word width must be positive");
   end

   logic [1:0] oack_s_q, cack_s_q;
   logic oack_prev_q, cack_prev_q;
   logic [WORD_W-1:0] w_s0_q, w_s1_q;
   logic oreq_q, creq_q;
   logic [OWH_CNT_W-1:0] olow_q, clow_q, clear_c;
   logic [WORD_W-1:0] rx_q;
   logic rxv_q, rxc_q;
   logic orise, crise;

   assign clear_c = fast_i ? OWH_CNT_W'(OWH_CLEAR_FAST_CYC) : OWH_CNT_W'(OWH_CLEAR_SLOW_CYC);

   // acknowledges and word lines are resynchronized together
   always_ff @(posedge clock_i) begin
      if (!resetn_i) begin
         oack_s_q <= 2'h0;
         cack_s_q <= 2'h0;
         oack_prev_q <= 1'b0;
         cack_prev_q <= 1'b0;
         w_s0_q <= '0;
         w_s1_q <= '0;
      end else begin
         oack_s_q <= {oack_s_q[0], link.out_ack};
         cack_s_q <= {cack_s_q[0], link.cmd_ack};
         oack_prev_q <= oack_s_q[1];
         cack_prev_q <= cack_s_q[1];
         w_s0_q <= link.word;
         w_s1_q <= w_s0_q;
      end
   end

   // word is settled well before the acknowledge, so edge sampling is safe
   assign orise = oack_s_q[1] && !oack_prev_q;
   assign crise = cack_s_q[1] && !cack_prev_q;

   always_ff @(posedge clock_i) begin
      if (!resetn_i) begin
         rx_q <= '0;
         rxv_q <= 1'b0;
         rxc_q <= 1'b0;
      end else begin
         rxv_q <= orise | crise;
         if (orise | crise) begin
            rx_q <= w_s1_q;
            rxc_q <= crise;
         end
      end
   end

   // requests: raised when ready, dropped on acknowledge, relaunched after low time
   always_ff @(posedge clock_i) begin
      if (!resetn_i) begin
         oreq_q <= 1'b0;
         creq_q <= 1'b0;
         olow_q <= '0;
         clow_q <= '0;
      end else begin
         if (oreq_q) olow_q <= '0;
         else if (olow_q != '1) olow_q <= olow_q + 1'b1;
         if (creq_q) clow_q <= '0;
         else if (clow_q != '1) clow_q <= clow_q + 1'b1;
         if (oreq_q && orise) oreq_q <= 1'b0;
         else if (!oreq_q && want_data_i && olow_q >= clear_c) oreq_q <= 1'b1;
         if (creq_q && crise) creq_q <= 1'b0;
         else if (!creq_q && want_cmd_i && clow_q >= clear_c) creq_q <= 1'b1;
      end
   end

   assign rx_word_o = rx_q;
   assign rx_valid_o = rxv_q;
   assign rx_cmd_o = rxc_q;
   assign link.out_req = oreq_q;
   assign link.cmd_req = creq_q;
endmodule : owh_peripheral

/* File: rtl/owh_pkg.sv */
// shared timing constants and types for the output word handshake channel
package owh_pkg;
   localparam int unsigned OWH_CLK_NS = 10;
   // minimum times in nanoseconds: _SLOW_ names the slow interface, _FAST_ the fast interface
   localparam int unsigned OWH_SETUP_SLOW_NS = 4200;
   localparam int unsigned OWH_SETUP_FAST_NS = 400;
   localparam int unsigned OWH_HOLD_SLOW_NS = 4300;
   localparam int unsigned OWH_HOLD_FAST_NS = 500;
   localparam int unsigned OWH_ACK_SLOW_NS = 8000;
   localparam int unsigned OWH_ACK_FAST_NS = 2200;
   localparam int unsigned OWH_VALID_SLOW_NS = 16700;
   localparam int unsigned OWH_VALID_FAST_NS = 3200;
   localparam int unsigned OWH_GAP_SLOW_NS = 2800;
   localparam int unsigned OWH_GAP_FAST_NS = 800;
   localparam int unsigned OWH_CLEAR_SLOW_NS = 7000;
   localparam int unsigned OWH_CLEAR_FAST_NS = 1200;
   // least times round up to whole cycles
   function automatic int unsigned owh_cycles(input int unsigned ns);
      int unsigned c;
      c = (ns + OWH_CLK_NS - 1) / OWH_CLK_NS;
      owh_cycles = (c < 1) ? 1 : c;
   endfunction : owh_cycles
   localparam int unsigned OWH_SETUP_SLOW_CYC = owh_cycles(OWH_SETUP_SLOW_NS);
   localparam int unsigned OWH_SETUP_FAST_CYC = owh_cycles(OWH_SETUP_FAST_NS);
   localparam int unsigned OWH_HOLD_SLOW_CYC = owh_cycles(OWH_HOLD_SLOW_NS);
   localparam int unsigned OWH_HOLD_FAST_CYC = owh_cycles(OWH_HOLD_FAST_NS);
   localparam int unsigned OWH_ACK_SLOW_CYC = owh_cycles(OWH_ACK_SLOW_NS);
   localparam int unsigned OWH_ACK_FAST_CYC = owh_cycles(OWH_ACK_FAST_NS);
   localparam int unsigned OWH_VALID_SLOW_CYC = owh_cycles(OWH_VALID_SLOW_NS);
   localparam int unsigned OWH_VALID_FAST_CYC = owh_cycles(OWH_VALID_FAST_NS);
   localparam int unsigned OWH_GAP_SLOW_CYC = owh_cycles(OWH_GAP_SLOW_NS);
   localparam int unsigned OWH_GAP_FAST_CYC = owh_cycles(OWH_GAP_FAST_NS);
   localparam int unsigned OWH_CLEAR_SLOW_CYC = owh_cycles(OWH_CLEAR_SLOW_NS);
   localparam int unsigned OWH_CLEAR_FAST_CYC = owh_cycles(OWH_CLEAR_FAST_NS);
   localparam int OWH_CNT_W = 12;
   localparam int OWH_WORD_W = 30;
   typedef enum logic [4:0] {
      OWH_IDLE = 5'h01,
      OWH_SETUP = 5'h02,
      OWH_ACK = 5'h04,
      OWH_HOLD = 5'h08,
      OWH_GAP = 5'h10
   } owh_state_type;
endpackage : owh_pkg

/* File: testbench/owh_props.sv */
// checker for the output word handshake lines
`timescale 1ns/1ps
module owh_props
   import owh_pkg::*;
#(
   parameter int WORD_W = OWH_WORD_W
) (
   // clock and reset
   input wire logic clock_i,
   input wire logic resetn_i,
   // link lines
   input wire logic [WORD_W-1:0] word,
   input wire logic out_ack,
   input wire logic cmd_ack,
   input wire logic out_req,
   input wire logic cmd_req
);
   // fast minimums bound both profiles, since every slow figure is longer
   logic [11:0] wst_q, ahi_q, alo_q, olo_q, clo_q;
   logic [WORD_W-1:0] word_q;
   logic any_ack;
   assign any_ack = out_ack | cmd_ack;
   function automatic logic [11:0] bump(input logic [11:0] v);
      bump = (v == 12'hFFF) ? v : v + 12'h001;
   endfunction : bump
   // low-time counters start saturated so the quiet reset period never reads as short
   always_ff @(posedge clock_i) begin
      if (!resetn_i) begin
         wst_q <= 12'h000;
         ahi_q <= 12'h000;
         alo_q <= 12'hFFF;
         olo_q <= 12'hFFF;
         clo_q <= 12'hFFF;
      end else begin
         wst_q <= (word == word_q) ? bump(wst_q) : 12'h000;
         ahi_q <= any_ack ? bump(ahi_q) : 12'h000;
         alo_q <= any_ack ? 12'h000 : bump(alo_q);
         olo_q <= out_req ? 12'h000 : bump(olo_q);
         clo_q <= cmd_req ? 12'h000 : bump(clo_q);
      end
   end
   always_ff @(posedge clock_i) begin
      word_q <= word;
   end
   default clocking cb @(posedge clock_i); endclocking
   default disable iff (!resetn_i);
   sequence s_out_released;
      ##[1:8] !out_req;
   endsequence
   sequence s_cmd_released;
      ##[1:8] !cmd_req;
   endsequence
   property p_setup;
      $rose(any_ack) |-> wst_q >= OWH_SETUP_FAST_CYC - 1;
   endproperty
   property p_ack_len;
      $fell(any_ack) |-> ahi_q >= OWH_ACK_FAST_CYC;
   endproperty
   property p_hold;
      (!any_ack && alo_q < OWH_HOLD_FAST_CYC) |-> $stable(word);
   endproperty
   property p_gap;
      $rose(any_ack) |-> alo_q >= OWH_GAP_FAST_CYC;
   endproperty
   property p_out_drop;
      $rose(out_ack) |-> s_out_released;
   endproperty
   property p_cmd_drop;
      $rose(cmd_ack) |-> s_cmd_released;
   endproperty
   property p_out_clear;
      $rose(out_req) |-> olo_q >= OWH_CLEAR_FAST_CYC;
   endproperty
   property p_cmd_clear;
      $rose(cmd_req) |-> clo_q >= OWH_CLEAR_FAST_CYC;
   endproperty
   a_setup: assert property (p_setup)
      else $error("acknowledge raised too soon after word change");
   a_ack_len: assert property (p_ack_len)
      else $error("acknowledge high too short");
   a_hold: assert property (p_hold)
      else $error("word changed too soon after acknowledge fell");
   a_gap: assert property (p_gap)
      else $error("acknowledge low gap too short");
   a_out_drop: assert property (p_out_drop)
      else $error("output request not dropped after acknowledge");
   a_cmd_drop: assert property (p_cmd_drop)
      else $error("command request not dropped after acknowledge");
   a_out_clear: assert property (p_out_clear)
      else $error("output request raised again too soon");
   a_cmd_clear: assert property (p_cmd_clear)
      else $error("command request raised again too soon");
endmodule : owh_props

/* File: testbench/testbench.sv */
// testbench joining both ends of the output word handshake channel
`timescale 1ns/1ps
module testbench
   import owh_pkg::*;
;
   logic clock_i, resetn_i, fast_i, send_valid_i, send_cmd_i, send_force_i, want_data_i, want_cmd_i;
   logic [OWH_WORD_W-1:0] send_word_i, rx_word_o;
   logic send_ready_o, out_pending_o, cmd_pending_o, rx_valid_o, rx_cmd_o;
   int failures = 0;
   int total_checks = 0;
   owh_link_if #(.WORD_W(OWH_WORD_W)) link ();
   owh_computer u_owh_computer (.clock_i(clock_i), .resetn_i(resetn_i), .fast_i(fast_i),
      .send_valid_i(send_valid_i), .send_cmd_i(send_cmd_i), .send_force_i(send_force_i),
      .send_word_i(send_word_i), .send_ready_o(send_ready_o), .out_pending_o(out_pending_o),
      .cmd_pending_o(cmd_pending_o), .link(link));
   owh_peripheral u_owh_peripheral (.clock_i(clock_i), .resetn_i(resetn_i), .fast_i(fast_i),
      .want_data_i(want_data_i), .want_cmd_i(want_cmd_i), .rx_word_o(rx_word_o), .rx_valid_o(rx_valid_o),
      .rx_cmd_o(rx_cmd_o), .link(link));
   owh_props u_owh_props (.clock_i(clock_i), .resetn_i(resetn_i), .word(link.word), .out_ack(link.out_ack),
      .cmd_ack(link.cmd_ack), .out_req(link.out_req), .cmd_req(link.cmd_req));
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         failures++;
         $display("wrong value %s expected %0h seen %0h", what, exp, seen);
      end
   endtask : check
   task automatic tally_and_finish;
      if (failures == 0 && total_checks > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask : tally_and_finish
   // offers one word when allowed, then follows it to the peripheral's capture
   task automatic xfer(input logic [OWH_WORD_W-1:0] w, input logic cmd, input logic frc, input int setup_min);
      int n;
      n = 0;
      while (n < 4000 && !(send_ready_o === 1'b1 && (frc || (cmd ? cmd_pending_o : out_pending_o) === 1'b1))) begin
         @(negedge clock_i);
         n++;
      end
      check("offer allowed", n < 4000, 1);
      send_valid_i = 1'b1;
      send_cmd_i = cmd;
      send_force_i = frc;
      send_word_i = w;
      @(negedge clock_i);
      send_valid_i = 1'b0;
      check("busy after take", send_ready_o, 0);
      check("pending after take", cmd ? cmd_pending_o : out_pending_o, 0);
      n = 0;
      while (n < 5000 && (link.out_ack | link.cmd_ack) !== 1'b1) begin
         @(negedge clock_i);
         n++;
      end
      check("setup cycles met", n >= setup_min, 1);
      check("word at acknowledge", link.word, w);
      check("acknowledge kind", {link.out_ack, link.cmd_ack}, {~cmd, cmd});
      n = 0;
      while (n < 20 && rx_valid_o !== 1'b1) begin
         @(negedge clock_i);
         n++;
      end
      check("capture pulse", n < 20, 1);
      check("captured word", rx_word_o, w);
      check("captured kind", rx_cmd_o, cmd);
      @(negedge clock_i);
      check("capture pulse ends", rx_valid_o, 0);
   endtask : xfer
   initial begin
      clock_i = 1'b0;
      forever #5 clock_i = ~clock_i;
   end
   // full run is under ten thousand cycles
   initial begin
      #400000;
      failures++;
      tally_and_finish();
   end
   initial begin
      resetn_i = 1'b0;
      fast_i = 1'b1;
      send_valid_i = 1'b0;
      send_cmd_i = 1'b0;
      send_force_i = 1'b0;
      send_word_i = 30'h0000_0000;
      want_data_i = 1'b0;
      want_cmd_i = 1'b0;
      repeat (5) @(negedge clock_i);
      resetn_i = 1'b1;
      repeat (300) @(negedge clock_i);
      check("requests while not ready", {out_pending_o, cmd_pending_o, link.out_req, link.cmd_req}, 0);
      want_data_i = 1'b1;
      xfer(30'h2AAA_5555, 1'b0, 1'b0, 40);
      xfer(30'h1555_AAAA, 1'b0, 1'b0, 40);
      want_data_i = 1'b0;
      want_cmd_i = 1'b1;
      xfer(30'h0000_0C3D, 1'b1, 1'b0, 40);
      want_cmd_i = 1'b0;
      for (int i = 0; i < 3; i++) begin
         xfer(30'h0000_0F00 + 30'(i), 1'b1, 1'b1, 40);
      end
      fast_i = 1'b0;
      want_data_i = 1'b1;
      xfer(30'h3FFF_FFFF, 1'b0, 1'b0, 420);
      xfer(30'h0F0F_0F0F, 1'b0, 1'b0, 420);
      tally_and_finish();
   end
endmodule : testbench
